// ### lpcfg_pkg.sv
package lpcfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_LOW_POWER_THRESHOLD_PERIOD = 16'hEC00;
  localparam logic [15:0] ADDR_REFERENCE_AND_PORT_LOCK    = 16'hEC01;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          LEVEL_LSB    = 0;
  localparam int          LEVEL_W      = 3;
  localparam int          LINES_LSB    = 3;
  localparam int          LINES_W      = 5;
  localparam int          EXTREF_BIT   = 0;
  localparam int          LOCK_BIT     = 1;
  localparam int          LEVEL_DIV_SH = 3;      // threshold = full scale * level / 8
  localparam logic [2:0]  LEVEL_RST    = 3'h7;
  localparam logic [4:0]  LINES_RST    = 5'h00;
  localparam logic        EXTREF_RST   = 1'b0;
  localparam logic [1:0]  TOGGLES_TO_SPI = 2'h3;

  // ----------------------------------------------------------------
  // timing: one line period is 1/50 s
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINE_TIME_MS  = 20;
  localparam int LINE_CYCLES   = LINE_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // host port selection, one-hot
  typedef enum logic [1:0]
  {
    PORT_I2C = 2'b01,
    PORT_SPI = 2'b10
  } port_e;

endpackage : lpcfg_pkg

// ### line_tick.sv
`timescale 1ns/1ps
module line_tick
  import lpcfg_pkg::*;
#(
  parameter int DIV = LINE_CYCLES
)
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);

  initial
  begin
    if (DIV < 2) $error("line_tick: DIV must be at least 2");
  end

  typedef struct packed
  {
    logic [31:0] cnt;
    logic        tick;
  } state_s;

  state_s st;
  state_s next_st;

  // ----------------------------------------------------------------
  // free-running divider, one-cycle enable each DIV cycles
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'(DIV - 1))
    begin
      next_st.cnt  = 32'h0;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick_o = st.tick;

endmodule : line_tick

// ### lpcfg_regs.sv
`timescale 1ns/1ps
// Functional notes
// R1: threshold equals full scale times three-bit level over eight; level resets 111.
// R2: measurement period is (line-period field + 1) fiftieths of a second.
// R3: reference-select bit chooses internal (0) or external (1) ADC reference.
// R4: unlocked, three toggles of port-select pin switch host port to SPI.
// R5: I2C active, host sets lock; pin toggles then ignored, no SPI switch.
// R6: SPI active, any write to second register locks port to SPI.
// R7: locked port choice survives every power-saving mode transition.
// R8: second register bits 7:2 have no function and read zero.
// R9: lock is sticky until full device reset; clearing writes ignored.
module lpcfg_regs
  import lpcfg_pkg::*;
#(
  parameter int THR_W       = 24,
  parameter int FULL_SCALE  = 24'h5A_0000,
  parameter int LINE_DIV    = LINE_CYCLES
)
(
  input  wire logic             CLK_I,
  input  wire logic             RSTN_I,
  input  wire logic [15:0]      ADDR_I,
  input  wire logic             WR_I,
  input  wire logic [7:0]       WDATA_I,
  input  wire logic             RD_I,
  input  wire logic             PORT_SEL_PIN_I,
  input  wire logic [1:0]       POWER_SAVING_MODES_I,
  output logic      [7:0]       RDATA_O,
  output logic      [THR_W-1:0] LOW_POWER_THRESHOLD_O,
  output logic                  LOW_POWER_PERIOD_END_O,
  output logic                  EXTERNAL_REFERENCE_SELECT_O,
  output logic                  SPI_ACTIVE_O,
  output logic                  PORT_LOCKED_O
);

  initial
  begin
    // 1 << 31 turns negative in an int, so the width check below needs THR_W at most 30
    if (THR_W < 4 || THR_W > 30) $error("lpcfg_regs: THR_W out of range");
    if (FULL_SCALE >= (1 << THR_W)) $error("lpcfg_regs: FULL_SCALE too wide");
  end

  // ----------------------------------------------------------------
  // reset release through two flops
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // line-period enable
  // ----------------------------------------------------------------
  logic line_tick_en;

  line_tick #(
    .DIV (LINE_DIV)
  ) u_line_tick (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .tick_o  (line_tick_en)
  );

  function automatic logic [THR_W-1:0] thr_of(input logic [2:0] lvl);
    logic [THR_W+2:0] prod;
    prod   = (THR_W+3)'(FULL_SCALE) * (THR_W+3)'(lvl);
    thr_of = THR_W'(prod >> LEVEL_DIV_SH);
  endfunction : thr_of

  // ----------------------------------------------------------------
  // block state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [2:0]       level;
    logic [4:0]       lines;
    logic             ext_ref;
    logic             locked;
    port_e            port;
    logic [1:0]       tog_cnt;
    logic             pin_q;
    logic [4:0]       line_cnt;
    logic             period_end;
    logic [7:0]       rdata;
    logic [THR_W-1:0] thr;
  } state_s;

  state_s st;
  state_s next_st;

  logic wr_thr;
  logic wr_cfg;
  logic rd_thr;
  logic rd_cfg;
  logic pin_fall;

  assign wr_thr   = WR_I && (ADDR_I == ADDR_LOW_POWER_THRESHOLD_PERIOD);
  assign wr_cfg   = WR_I && (ADDR_I == ADDR_REFERENCE_AND_PORT_LOCK);
  assign rd_thr   = RD_I && (ADDR_I == ADDR_LOW_POWER_THRESHOLD_PERIOD);
  assign rd_cfg   = RD_I && (ADDR_I == ADDR_REFERENCE_AND_PORT_LOCK);
  assign pin_fall = st.pin_q && !PORT_SEL_PIN_I;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // no power-mode term touches lock or port: only reset clears them [R7]
  always_comb
  begin
    next_st            = st;
    next_st.pin_q      = PORT_SEL_PIN_I;
    next_st.period_end = 1'b0;

    // register writes
    if (wr_thr)
    begin
      next_st.level = WDATA_I[LEVEL_LSB +: LEVEL_W];
      next_st.lines = WDATA_I[LINES_LSB +: LINES_W];
    end
    if (wr_cfg)
    begin
      next_st.ext_ref = WDATA_I[EXTREF_BIT];                    // [R3]
    end

    // port selection and lock
    case (st.port)
      PORT_I2C:
      begin
        if (wr_cfg && WDATA_I[LOCK_BIT])
          next_st.locked = 1'b1;                                // [R5]
        // a locked I2C port ignores the pin entirely
        if (!st.locked && pin_fall)                             // [R5]
        begin
          if (st.tog_cnt == TOGGLES_TO_SPI - 2'h1)
          begin
            next_st.port    = PORT_SPI;                         // [R4]
            next_st.tog_cnt = 2'h0;
          end
          else
          begin
            next_st.tog_cnt = st.tog_cnt + 2'h1;                // [R4]
          end
        end
      end
      PORT_SPI:
      begin
        // any write locks, whatever the lock bit carries
        if (wr_cfg)
          next_st.locked = 1'b1;                                // [R6]
      end
      default:
      begin
        next_st.port = PORT_I2C;
      end
    endcase

    // lock never falls back once set; a zero write cannot undo it
    if (st.locked)
      next_st.locked = 1'b1;                                    // [R9]

    // measurement period counted in whole line periods
    if (wr_thr)
    begin
      next_st.line_cnt = 5'h00;
    end
    else if (line_tick_en)
    begin
      if (st.line_cnt == st.lines)
      begin
        next_st.line_cnt   = 5'h00;
        next_st.period_end = 1'b1;                              // [R2]
      end
      else
      begin
        next_st.line_cnt = st.line_cnt + 5'h01;
      end
    end

    // threshold follows the level field
    next_st.thr = thr_of(next_st.level);                        // [R1]

    // read data, unmapped addresses return zero
    if (rd_thr)
      next_st.rdata = {st.lines, st.level};
    else if (rd_cfg)
      next_st.rdata = {6'h00, st.locked, st.ext_ref};           // [R8]
    else if (RD_I)
      next_st.rdata = 8'h00;
  end

  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st         <= '0;
      st.level   <= LEVEL_RST;                                  // [R1]
      st.lines   <= LINES_RST;
      st.ext_ref <= EXTREF_RST;
      st.port    <= PORT_I2C;
      st.pin_q   <= 1'b1;
      st.thr     <= thr_of(LEVEL_RST);
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from state flops
  // ----------------------------------------------------------------
  assign RDATA_O                     = st.rdata;
  assign LOW_POWER_THRESHOLD_O       = st.thr;
  assign LOW_POWER_PERIOD_END_O      = st.period_end;
  assign EXTERNAL_REFERENCE_SELECT_O = st.ext_ref;
  assign SPI_ACTIVE_O                = st.port[1];          // one-hot code: bit 1 is the SPI flop
  assign PORT_LOCKED_O               = st.locked;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_wr_thr;
    wr_thr;
  endsequence
  sequence s_wr_cfg;
    wr_cfg;
  endsequence

  property p_thr;
    s_wr_thr |=> LOW_POWER_THRESHOLD_O == thr_of($past(WDATA_I[2:0]));
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not level/8 of full scale"); // [R1]

  property p_period;
    !wr_thr && line_tick_en && st.line_cnt == st.lines |=> LOW_POWER_PERIOD_END_O ##1 !LOW_POWER_PERIOD_END_O;
  endproperty
  a_period: assert property (p_period) else $error("period end not after lines+1 ticks"); // [R2]

  property p_ref;
    s_wr_cfg |=> EXTERNAL_REFERENCE_SELECT_O == $past(WDATA_I[0]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select not written"); // [R3]

  property p_toggle;
    !st.locked && !SPI_ACTIVE_O && pin_fall && st.tog_cnt == 2'h2 |=> SPI_ACTIVE_O;
  endproperty
  a_toggle: assert property (p_toggle) else $error("third toggle did not select SPI"); // [R4]

  property p_i2c_hold;
    PORT_LOCKED_O && !SPI_ACTIVE_O |=> !SPI_ACTIVE_O [*2];
  endproperty
  a_i2c_hold: assert property (p_i2c_hold) else $error("locked I2C switched to SPI"); // [R5]

  property p_spi_lock;
    SPI_ACTIVE_O ##0 s_wr_cfg |=> PORT_LOCKED_O && SPI_ACTIVE_O;
  endproperty
  a_spi_lock: assert property (p_spi_lock) else $error("SPI write did not lock"); // [R6]

  property p_psm;
    PORT_LOCKED_O && $changed(POWER_SAVING_MODES_I) |=> PORT_LOCKED_O && $stable(SPI_ACTIVE_O);
  endproperty
  a_psm: assert property (p_psm) else $error("port choice lost on power mode change"); // [R7]

  property p_rsvd;
    rd_cfg |=> RDATA_O[7:2] == 6'h00 && RDATA_O[1] == $past(st.locked);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero"); // [R8]

  property p_sticky;
    PORT_LOCKED_O |=> PORT_LOCKED_O;
  endproperty
  a_sticky: assert property (p_sticky) else $error("lock cleared without reset"); // [R9]

endmodule : lpcfg_regs

// ### host_pin.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side of the port-select pin
// ----------------------------------------------------------------
module host_pin
(
  input  wire logic clk_i,
  output logic      pin_o
);
  // pin idles high, so a pin held at reset never reads as a toggle
  initial pin_o = 1'b1;

  // each level is held a full cycle so every fall is seen
  task automatic toggle(input int n);
    repeat (n)
    begin
      @(negedge clk_i);
      pin_o = 1'b0;
      @(negedge clk_i);
      pin_o = 1'b1;
    end
  endtask : toggle
endmodule : host_pin

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
  import lpcfg_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [15:0] A0 = ADDR_LOW_POWER_THRESHOLD_PERIOD;
  localparam logic [15:0] A1 = ADDR_REFERENCE_AND_PORT_LOCK;
  logic        CLK_I, RSTN_I, WR_I, RD_I, PIN, PEND, EXT, SPI, LCK;
  logic [15:0] ADDR_I;
  logic [7:0]  WDATA_I, RDATA_O;
  logic [1:0]  PSM;
  logic [23:0] THR;
  int          mismatches, checked, n;

  lpcfg_regs #(.LINE_DIV(8)) i_dut
  (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .WDATA_I(WDATA_I),
   .RD_I(RD_I), .PORT_SEL_PIN_I(PIN), .POWER_SAVING_MODES_I(PSM), .RDATA_O(RDATA_O),
   .LOW_POWER_THRESHOLD_O(THR), .LOW_POWER_PERIOD_END_O(PEND),
   .EXTERNAL_REFERENCE_SELECT_O(EXT), .SPI_ACTIVE_O(SPI), .PORT_LOCKED_O(LCK));
  host_pin i_host (.clk_i(CLK_I), .pin_o(PIN));

  // 100 MHz clock
  initial
  begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // reset held 5 cycles; first access waits for the two-flop release
  task automatic do_reset();
    RSTN_I = 1'b0;
    repeat (5) @(negedge CLK_I);
    RSTN_I = 1'b1;
    repeat (3) @(negedge CLK_I);
  endtask : do_reset

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge CLK_I);
    ADDR_I = a;
    WDATA_I = d;
    WR_I = 1'b1;
    @(negedge CLK_I);
    WR_I = 1'b0;
  endtask : wr

  // read data is registered on the edge that samples the strobe; checked at the next falling edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge CLK_I);
    ADDR_I = a;
    RD_I = 1'b1;
    @(negedge CLK_I);
    RD_I = 1'b0;
    chk(RDATA_O, exp, "read data");
  endtask : rd

  // bounded wait for the one-cycle period pulse; returns cycles waited
  task automatic wait_pend(output int c);
    c = 0;
    do
    begin
      @(negedge CLK_I);
      c++;
    end while (PEND !== 1'b1 && c < 200);
    if (c >= 200)
    begin
      mismatches++;
      $display("FAIL %0t period pulse missing", $time);
      close_out();
    end
  endtask : wait_pend

  task automatic chk_reset();
    chk(THR, 32'h5A0000 * 7 / 8, "reset threshold");
    chk(EXT, 1'b0, "reset ref select");
    chk(SPI, 1'b0, "reset port");
    rd(A0, 8'h07);
    rd(A1, 8'h00);
  endtask : chk_reset

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {WR_I, RD_I, ADDR_I, WDATA_I, PSM} = '0;
    do_reset();
    chk_reset();
    $display("test reset done");
    // every level code sets the threshold to full scale times level over eight
    for (int l = 0; l < 8; l++)
    begin
      wr(A0, {5'h00, l[2:0]});
      chk(THR, 32'h5A0000 * l / 8, "threshold");
    end
    // period of (lines + 1) line ticks, line tick scaled to 8 cycles
    for (int p = 0; p < 2; p++)
    begin
      wr(A0, {p[4:0] ^ 5'h03, 3'h2});
      wait_pend(n);
      wait_pend(n);
      chk(n, ((p ^ 3) + 1) * 8, "period length");
    end
    rd(A0, 8'h12);
    $display("test threshold and period done");
    // lock from I2C, then try to clear it and to switch by pin
    wr(A1, 8'hFF);
    chk(EXT, 1'b1, "external ref");
    chk(LCK, 1'b1, "lock set");
    rd(A1, 8'h03);
    wr(A1, 8'h00);
    chk(EXT, 1'b0, "internal ref");
    rd(A1, 8'h02);
    i_host.toggle(3);
    repeat (2) @(negedge CLK_I);
    chk(SPI, 1'b0, "pin ignored when locked");
    for (int m = 0; m < 4; m++)
    begin
      PSM = m[1:0];
      repeat (2) @(negedge CLK_I);
      chk({SPI, LCK}, 2'b01, "port kept across modes");
    end
    wr(16'hEC02, 8'h55);
    rd(16'hEC02, 8'h00);
    rd(A0, 8'h12);
    // write and read in one strobe cycle: the read returns the old value
    @(negedge CLK_I);
    {ADDR_I, WDATA_I, WR_I, RD_I} = {A0, 8'h13, 2'b11};
    @(negedge CLK_I);
    {WR_I, RD_I} = 2'b00;
    chk(RDATA_O, 8'h12, "read beside write");
    rd(A0, 8'h13);
    $display("test i2c lock done");
    // second reset clears the lock; three toggles then move to SPI
    do_reset();
    chk_reset();
    chk(LCK, 1'b0, "lock cleared by reset");
    i_host.toggle(2);
    repeat (2) @(negedge CLK_I);
    chk(SPI, 1'b0, "two toggles");
    i_host.toggle(1);
    repeat (2) @(negedge CLK_I);
    chk(SPI, 1'b1, "third toggle");
    chk(LCK, 1'b0, "spi not yet locked");
    wr(A1, 8'h00);
    chk({SPI, LCK}, 2'b11, "spi locked by write");
    PSM = 2'h2;
    repeat (2) @(negedge CLK_I);
    chk({SPI, LCK}, 2'b11, "spi kept across modes");
    $display("test spi lock done");
    close_out();
  end
endmodule : tb_top
